/* verilog/dce_executor.sv */
// Disk command executor: host link, command decode and media sequencing
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_executor
  import dce_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire dce_pkg::dce_link_in_s link_in,
  output dce_pkg::dce_link_out_s     link_out,
  input  wire logic [7:0]            unit_ready,
  output dce_pkg::dce_mreq_s         med_req,
  input  wire dce_pkg::dce_mrsp_s    med_rsp,
  input  wire dce_pkg::dce_mrd_s     med_rd,
  output logic                       med_wr_valid,
  output logic [7:0]                 med_wr_byte,
  input  wire dce_pkg::dce_reg_s     reg_in,
  output logic [7:0]                 reg_rdata
);
  import dce_pkg::*;

  typedef struct packed {
    dce_ph_e        ph;
    dce_link_out_s  link;
    logic           wait_rel;
    logic           prime;
    logic [9:0][7:0] cdb;
    logic [8:0]     idx;
    logic [8:0]     xlen;
    logic [8:0]     left;
    logic [2:0]     unit;
    logic [20:0]    lba;
    logic [2:0]     dunit;
    logic [20:0]    dlba;
    logic           copy;
    logic           wr;
    logic           bad;
    logic           st_err;
    logic           st_par;
    logic [7:0]     sense;
    logic [2:0]     sunit;
    logic [20:0]    slba;
    logic [7:0]     syn_off;
    logic [7:0]     syn;
    dce_src_e       src;
    logic [7:0][1:0] fmt;
    logic [7:0]     flop;
    dce_mreq_s      med;
    logic           mw_valid;
    logic           par_en;
    logic [7:0]     last_st;
    logic [7:0]     rdata;
    logic [5:0]     slot;
    logic [8:0]     trk;
    logic           all_trk;
    logic [20:0]    tlba;
    logic [5:0]     spt;
  } dce_st_s;

  localparam dce_link_out_s LINK_IDLE = '{
    data_b: 8'hFF, par_b: 1'b1, data_oe: 1'b0, busy_b: 1'b1,
    msg_b: 1'b1, cd_b: 1'b1, req_b: 1'b1, io_b: 1'b1};

  dce_st_s     s_ff;
  dce_st_s     nxt_s;
  logic        take;
  logic        rel;
  logic        pok;
  logic        adv;
  logic        inv;
  logic        il_clr;
  logic        il_step;
  logic        mem_we;
  logic [7:0]  mem_wd;
  logic [7:0]  mem_rd;
  logic [7:0]  din;
  logic [7:0]  ob;
  logic [7:0]  cnt;
  logic [3:0]  clen;
  logic [2:0]  u0;
  logic [20:0] a0;
  logic [20:0] nl;
  logic [8:0]  sz0;
  logic [5:0]  il_pos;
  logic        il_ok;

  function automatic logic [8:0] secsz(input logic fl, input logic dd, input logic [20:0] a);
    if (!fl) begin
      secsz = `DCE_SZ_LONG;
    end else if (dd && a >= `DCE_FLOP_TRK0_END) begin
      secsz = `DCE_SZ_LONG;
    end else begin
      secsz = `DCE_SZ_SHORT;
    end
  endfunction : secsz

  function automatic dce_mreq_s mreq(input dce_mop_e op, input logic [2:0] u,
                                     input logic [20:0] a, input logic [8:0] sz);
    mreq       = '0;
    mreq.valid = 1'b1;
    mreq.op    = op;
    mreq.unit  = u;
    mreq.lba   = a;
    mreq.size  = sz;
    mreq.mfm   = sz[8];
    mreq.fill  = `DCE_FILL_BYTE;
  endfunction : mreq

  always_comb begin
    nxt_s   = s_ff;
    take    = !s_ff.link.req_b && !link_in.ack_b;
    rel     = s_ff.wait_rel && link_in.ack_b;
    din     = ~link_in.data_b;
    pok     = !s_ff.par_en || ^{din, ~link_in.par_b};
    adv     = 1'b0;
    inv     = 1'b0;
    il_clr  = 1'b0;
    il_step = 1'b0;
    mem_we  = 1'b0;
    mem_wd  = din;
    u0      = s_ff.cdb[1][7:5];
    a0      = {s_ff.cdb[1][4:0], s_ff.cdb[2], s_ff.cdb[3]};
    cnt     = s_ff.cdb[4];
    nl      = s_ff.lba + 21'h000001;
    sz0     = secsz(s_ff.flop[u0], s_ff.fmt[u0][1], a0);
    il_ok   = cnt != 8'h00 && cnt <= `DCE_IL_MAX;
    clen    = (s_ff.cdb[0][7:5] == `DCE_CLS_COPY) ? `DCE_LEN_10 : `DCE_LEN_6;
    nxt_s.med.valid = 1'b0;
    nxt_s.mw_valid  = 1'b0;
    nxt_s.rdata     = 8'h00;
    if (s_ff.ph == PH_STAT) begin
      ob = 8'h00;
      ob[`DCE_ST_UNIT] = s_ff.unit;
      ob[`DCE_ST_ERR]  = s_ff.st_err;
      ob[`DCE_ST_PAR]  = s_ff.st_par;
    end else if (s_ff.ph == PH_MSG) begin
      ob = 8'h00;
    end else if (s_ff.src == SRC_SYN) begin
      ob = s_ff.idx[0] ? s_ff.syn : s_ff.syn_off;
    end else if (s_ff.src == SRC_SENSE) begin
      ob = (s_ff.idx[1:0] == 2'h0) ? s_ff.sense :
           (s_ff.idx[1:0] == 2'h1) ? {s_ff.sunit, s_ff.slba[20:16]} :
           (s_ff.idx[1:0] == 2'h2) ? s_ff.slba[15:8] : s_ff.slba[7:0];
    end else begin
      ob = mem_rd;
    end
    if (reg_in.we && reg_in.addr == `DCE_REG_CTRL) begin
      nxt_s.par_en = reg_in.wdata[0];
    end
    if (reg_in.re) begin
      if (reg_in.addr == `DCE_REG_CTRL) begin
        nxt_s.rdata = {7'h00, s_ff.par_en};
      end else if (reg_in.addr == `DCE_REG_STATUS) begin
        nxt_s.rdata = s_ff.last_st;
      end else if (reg_in.addr == `DCE_REG_SENSE) begin
        nxt_s.rdata = s_ff.sense;
      end else if (reg_in.addr == `DCE_REG_PHASE) begin
        nxt_s.rdata = {4'h0, s_ff.ph};
      end
    end
    // Handshake: take on ack, then wait for ack release before the next byte
    if (take) begin
      nxt_s.link.req_b = 1'b1;
      nxt_s.wait_rel   = 1'b1;
    end
    if (rel) begin
      nxt_s.wait_rel = 1'b0;
    end
    if (!link_in.rst_b) begin
      nxt_s.ph       = PH_IDLE;
      nxt_s.wait_rel = 1'b0;
      nxt_s.prime    = 1'b0;
      nxt_s.link     = LINK_IDLE;
    end else begin
      unique case (s_ff.ph)
        PH_IDLE: begin
          if (!link_in.sel_b) begin
            nxt_s.ph     = PH_CMD;
            nxt_s.idx    = 9'h000;
            nxt_s.st_err = 1'b0;
            nxt_s.st_par = 1'b0;
            nxt_s.copy   = 1'b0;
            nxt_s.wr     = 1'b0;
            nxt_s.bad    = 1'b0;
            nxt_s.all_trk = 1'b0;
          end
        end
        PH_CMD, PH_HIN: begin
          if (s_ff.link.req_b && !s_ff.wait_rel) begin
            nxt_s.link.req_b = 1'b0;
          end
          if (take) begin
            if (s_ff.ph == PH_CMD) begin
              nxt_s.cdb[s_ff.idx[3:0]] = din;
            end else begin
              mem_we = 1'b1;
            end
            if (!pok) begin
              nxt_s.st_par = 1'b1;
              nxt_s.st_err = 1'b1;
              nxt_s.sense  = `DCE_SNS_PARITY;
            end
          end
          if (rel) begin
            nxt_s.idx = s_ff.idx + 9'h001;
            if (s_ff.st_par) begin
              // Status waits for ack release, or that release would skip it
              nxt_s.ph = PH_STAT;
            end else if (s_ff.ph == PH_CMD && s_ff.idx + 9'h001 == {5'h00, clen}) begin
              nxt_s.ph = PH_EXEC;
            end else if (s_ff.ph == PH_HIN && s_ff.idx + 9'h001 == s_ff.xlen) begin
              nxt_s.idx = 9'h000;
              nxt_s.ph  = PH_MEDS;
            end
          end
        end
        PH_EXEC: begin
          nxt_s.unit  = u0;
          nxt_s.lba   = a0;
          nxt_s.left  = (cnt == 8'h00) ? 9'h100 : {1'b0, cnt};
          nxt_s.dunit = s_ff.cdb[5][7:5];
          nxt_s.dlba  = {s_ff.cdb[5][4:0], s_ff.cdb[6], s_ff.cdb[7]};
          nxt_s.idx   = 9'h000;
          nxt_s.xlen  = sz0;
          nxt_s.ph    = PH_STAT;
          nxt_s.spt   = s_ff.flop[u0] ? `DCE_FLOP_SPT : `DCE_HD_SPT;
          nxt_s.slot  = 6'h00;
          nxt_s.trk   = 9'h000;
          nxt_s.tlba  = a0;
          il_clr      = 1'b1;
          if (s_ff.cdb[0][7:5] == `DCE_CLS_UTIL) begin
            case (s_ff.cdb[0][4:0])
              `DCE_OPC_TEST: begin
                if (!unit_ready[u0]) begin
                  nxt_s.st_err = 1'b1;
                  nxt_s.sense  = `DCE_SNS_NOT_READY;
                  nxt_s.sunit  = u0;
                  nxt_s.slba   = a0;
                end
              end
              `DCE_OPC_RECAL: begin
                nxt_s.med = mreq(MOP_RECAL, u0, a0, sz0);
                nxt_s.ph  = PH_WAIT;
              end
              `DCE_OPC_SYND: begin
                if (s_ff.cdb[`DCE_BI_CTL6][`DCE_CTL_ECC_OFF]) begin
                  nxt_s.src  = SRC_SYN;
                  nxt_s.xlen = 9'h002;
                  nxt_s.ph   = PH_HOUT;
                end else begin
                  inv = 1'b1;
                end
              end
              `DCE_OPC_SENSE: begin
                nxt_s.src  = SRC_SENSE;
                nxt_s.xlen = 9'h004;
                nxt_s.ph   = PH_HOUT;
              end
              `DCE_OPC_FMT_DRV: begin
                nxt_s.all_trk = 1'b1;
                nxt_s.tlba    = 21'h000000;
                nxt_s.ph      = il_ok ? PH_FMT : PH_STAT;
                inv           = !il_ok;
              end
              `DCE_OPC_CHK_TRK: begin
                nxt_s.med = mreq(MOP_CHECK, u0, a0, sz0);
                nxt_s.ph  = PH_WAIT;
              end
              `DCE_OPC_FMT_TRK: begin
                nxt_s.ph = il_ok ? PH_FMT : PH_STAT;
                inv      = !il_ok;
              end
              `DCE_OPC_FMT_BAD: begin
                nxt_s.bad = 1'b1;
                nxt_s.ph  = il_ok ? PH_FMT : PH_STAT;
                inv       = !il_ok;
              end
              `DCE_OPC_READ: begin
                nxt_s.med = mreq(MOP_READ, u0, a0, sz0);
                nxt_s.ph  = PH_WAIT;
              end
              `DCE_OPC_WRITE: begin
                nxt_s.wr = 1'b1;
                nxt_s.ph = PH_HIN;
              end
              `DCE_OPC_SEEK: begin
                nxt_s.med = mreq(MOP_SEEK, u0, a0, sz0);
                nxt_s.ph  = PH_WAIT;
              end
              default: begin
                inv = 1'b1;
              end
            endcase
          end else if (s_ff.cdb[0][7:5] == `DCE_CLS_COPY &&
                       s_ff.cdb[0][4:0] == `DCE_OPC_COPY) begin
            nxt_s.copy = 1'b1;
            nxt_s.med  = mreq(MOP_READ, u0, a0, sz0);
            nxt_s.ph   = PH_WAIT;
          end else if (s_ff.cdb[0][7:5] == `DCE_CLS_FLOP &&
                       s_ff.cdb[0][4:0] == `DCE_OPC_FLOP_FMT) begin
            nxt_s.fmt[u0]  = s_ff.cdb[4][1:0];
            nxt_s.flop[u0] = 1'b1;
          end else begin
            inv = 1'b1;
          end
          if (inv) begin
            nxt_s.st_err = 1'b1;
            nxt_s.sense  = `DCE_SNS_BAD_CMD;
            nxt_s.sunit  = u0;
            nxt_s.slba   = a0;
          end
        end
        PH_FMT: begin
          nxt_s.med = mreq(MOP_IDFMT, s_ff.unit, s_ff.tlba,
                           secsz(s_ff.flop[s_ff.unit], s_ff.fmt[s_ff.unit][1], s_ff.tlba));
          nxt_s.med.phys    = il_pos;
          nxt_s.med.logical = s_ff.slot;
          nxt_s.med.bad     = s_ff.bad;
          nxt_s.ph          = PH_WAIT;
        end
        PH_MEDS: begin
          // Bytes go out first; the write itself is only ordered once all xlen bytes have gone out
          if (s_ff.idx != s_ff.xlen) begin
            nxt_s.mw_valid = 1'b1;
            nxt_s.idx      = s_ff.idx + 9'h001;
          end else begin
            nxt_s.med = mreq(MOP_WRITE, s_ff.copy ? s_ff.dunit : s_ff.unit,
                             s_ff.copy ? s_ff.dlba : s_ff.lba, s_ff.xlen);
            nxt_s.ph  = PH_WAIT;
          end
        end
        PH_WAIT: begin
          if (med_rd.valid) begin
            mem_we    = 1'b1;
            mem_wd    = med_rd.data;
            nxt_s.idx = s_ff.idx + 9'h001;
          end
          if (med_rsp.done) begin
            nxt_s.idx = 9'h000;
            if (med_rsp.err) begin
              nxt_s.st_err  = 1'b1;
              nxt_s.sense   = `DCE_SNS_MEDIA;
              nxt_s.sunit   = s_ff.med.unit;
              nxt_s.slba    = s_ff.med.lba;
              nxt_s.syn_off = med_rsp.ecc_off;
              nxt_s.syn     = {med_rsp.ecc_start, 1'b0, med_rsp.ecc_pat};
              nxt_s.ph      = PH_STAT;
            end else begin
              unique case (s_ff.med.op)
                MOP_READ: begin
                  nxt_s.src = SRC_BUF;
                  nxt_s.ph  = s_ff.copy ? PH_MEDS : PH_HOUT;
                end
                MOP_WRITE: begin
                  adv = 1'b1;
                end
                MOP_IDFMT: begin
                  nxt_s.slot = s_ff.slot + 6'h01;
                  il_step    = 1'b1;
                  nxt_s.ph   = PH_FMT;
                  if (s_ff.slot + 6'h01 == s_ff.spt) begin
                    nxt_s.slot = 6'h00;
                    il_clr     = 1'b1;
                    nxt_s.trk  = s_ff.trk + 9'h001;
                    nxt_s.tlba = s_ff.tlba + {15'h0000, s_ff.spt};
                    if (!s_ff.all_trk || s_ff.trk == `DCE_HD_LAST_TRK) begin
                      nxt_s.ph = PH_STAT;
                    end
                  end
                end
                default: begin
                  nxt_s.ph = PH_STAT;
                end
              endcase
            end
          end
        end
        PH_HOUT, PH_STAT, PH_MSG: begin
          // One idle cycle lets the buffer read data settle before the byte is driven
          if (s_ff.link.req_b && !s_ff.wait_rel) begin
            if (!s_ff.prime) begin
              nxt_s.prime = 1'b1;
            end else begin
              nxt_s.prime       = 1'b0;
              nxt_s.link.data_b = ~ob;
              nxt_s.link.par_b  = ^ob;
              nxt_s.link.req_b  = 1'b0;
              if (s_ff.ph == PH_STAT) begin
                nxt_s.last_st = ob;
              end
            end
          end
          if (rel) begin
            nxt_s.idx = s_ff.idx + 9'h001;
            if (s_ff.ph == PH_STAT) begin
              nxt_s.ph = PH_MSG;
            end else if (s_ff.ph == PH_MSG) begin
              nxt_s.ph = PH_IDLE;
            end else if (s_ff.idx + 9'h001 == s_ff.xlen) begin
              nxt_s.ph = PH_STAT;
              adv      = s_ff.src == SRC_BUF;
            end
          end
        end
      endcase
      if (adv) begin
        nxt_s.left = s_ff.left - 9'h001;
        nxt_s.lba  = nl;
        nxt_s.dlba = s_ff.dlba + 21'h000001;
        nxt_s.idx  = 9'h000;
        nxt_s.xlen = secsz(s_ff.flop[s_ff.unit], s_ff.fmt[s_ff.unit][1], nl);
        if (s_ff.left == 9'h001) begin
          nxt_s.ph = PH_STAT;
        end else if (s_ff.wr) begin
          nxt_s.ph = PH_HIN;
        end else begin
          nxt_s.med = mreq(MOP_READ, s_ff.unit, nl, nxt_s.xlen);
          nxt_s.ph  = PH_WAIT;
        end
      end
      // Phase lines follow the next phase so they change with it
      nxt_s.link.data_oe = nxt_s.ph inside {PH_HOUT, PH_STAT, PH_MSG};
      nxt_s.link.io_b    = !(nxt_s.ph inside {PH_HOUT, PH_STAT, PH_MSG});
      nxt_s.link.cd_b    = !(nxt_s.ph inside {PH_CMD, PH_STAT, PH_MSG});
      nxt_s.link.msg_b   = nxt_s.ph != PH_MSG;
      nxt_s.link.busy_b  = nxt_s.ph == PH_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_ff        <= '0;
      s_ff.link   <= LINK_IDLE;
      s_ff.par_en <= `DCE_CTRL_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  dce_sector_mem u_mem (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .addr     (s_ff.idx[7:0]),
    .we       (mem_we),
    .wdata    (mem_wd),
    .rdata_ff (mem_rd)
  );

  dce_interleave u_il (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clr     (il_clr),
    .step    (il_step),
    .code    (s_ff.cdb[4][4:0]),
    .count   (s_ff.spt),
    .pos     (il_pos)
  );

  assign link_out     = s_ff.link;
  assign med_req      = s_ff.med;
  assign med_wr_valid = s_ff.mw_valid;
  assign med_wr_byte  = mem_rd;
  assign reg_rdata    = s_ff.rdata;
endmodule : dce_executor

/* verilog/dce_defines.svh */
// Constants of the disk command executor
`ifndef DCE_DEFINES_SVH
`define DCE_DEFINES_SVH
`define DCE_CLS_UTIL      3'h0
`define DCE_CLS_COPY      3'h1
`define DCE_CLS_FLOP      3'h6
`define DCE_OPC_TEST      5'h00
`define DCE_OPC_RECAL     5'h01
`define DCE_OPC_SYND      5'h02
`define DCE_OPC_SENSE     5'h03
`define DCE_OPC_FMT_DRV   5'h04
`define DCE_OPC_CHK_TRK   5'h05
`define DCE_OPC_FMT_TRK   5'h06
`define DCE_OPC_FMT_BAD   5'h07
`define DCE_OPC_READ      5'h08
`define DCE_OPC_WRITE     5'h0A
`define DCE_OPC_SEEK      5'h0B
`define DCE_OPC_COPY      5'h00
`define DCE_OPC_FLOP_FMT  5'h00
`define DCE_LEN_SHORT     4'hA
`define DCE_LEN_6         4'h6
`define DCE_LEN_10        4'hA
`define DCE_BI_COUNT      1'b0
`define DCE_BI_CTL6       5
`define DCE_BI_CTL10      9
`define DCE_CTL_ECC_OFF   6
`define DCE_ST_PAR        0
`define DCE_ST_ERR        1
`define DCE_ST_UNIT       7:5
`define DCE_SNS_NOT_READY 8'h04
`define DCE_SNS_MEDIA     8'h11
`define DCE_SNS_PARITY    8'h1A
`define DCE_SNS_BAD_CMD   8'h20
`define DCE_FILL_BYTE     8'h6C
`define DCE_IL_MAX        8'h10
`define DCE_FLOP_SPT      6'h1A
`define DCE_HD_SPT        6'h20
`define DCE_HD_LAST_TRK   9'h0FF
`define DCE_SZ_LONG       9'h100
`define DCE_SZ_SHORT      9'h080
`define DCE_FLOP_TRK0_END 21'h00001A
`define DCE_MEM_DEPTH     256
`define DCE_REG_CTRL      4'h0
`define DCE_REG_STATUS    4'h1
`define DCE_REG_SENSE     4'h2
`define DCE_REG_PHASE     4'h3
`define DCE_CTRL_RESET    1'b1
`endif

/* verilog/dce_pkg.sv */
// Types of the disk command executor
package dce_pkg;
  typedef enum logic [3:0] {
    PH_IDLE, PH_CMD, PH_EXEC, PH_HIN, PH_HOUT, PH_MEDS, PH_WAIT, PH_FMT, PH_STAT, PH_MSG
  } dce_ph_e;
  typedef enum logic [2:0] {
    MOP_READ, MOP_WRITE, MOP_SEEK, MOP_RECAL, MOP_CHECK, MOP_IDFMT
  } dce_mop_e;
  typedef enum logic [1:0] {SRC_BUF, SRC_SYN, SRC_SENSE} dce_src_e;
  typedef struct packed {
    logic        valid;
    dce_mop_e    op;
    logic [2:0]  unit;
    logic [20:0] lba;
    logic [5:0]  phys;
    logic [5:0]  logical;
    logic        bad;
    logic [7:0]  fill;
    logic        mfm;
    logic [8:0]  size;
  } dce_mreq_s;
  typedef struct packed {
    logic       done;
    logic       err;
    logic [7:0] ecc_off;
    logic [2:0] ecc_start;
    logic [3:0] ecc_pat;
  } dce_mrsp_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dce_mrd_s;
  typedef struct packed {
    logic [7:0] data_b;
    logic       par_b;
    logic       ack_b;
    logic       rst_b;
    logic       sel_b;
  } dce_link_in_s;
  typedef struct packed {
    logic [7:0] data_b;
    logic       par_b;
    logic       data_oe;
    logic       busy_b;
    logic       msg_b;
    logic       cd_b;
    logic       req_b;
    logic       io_b;
  } dce_link_out_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } dce_reg_s;
  typedef struct packed {
    logic [5:0] pos;
    logic [5:0] base;
  } dce_il_s;
endpackage : dce_pkg

/* verilog/dce_sector_mem.sv */
// Sector buffer memory with registered read data
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_sector_mem (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_ff
);
  logic [7:0] mem [0:`DCE_MEM_DEPTH-1];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= mem[addr];
    end
  end
endmodule : dce_sector_mem

/* verilog/dce_interleave.sv */
// Physical slot stepper for sector interleave
`timescale 1ns/1ps
module dce_interleave
  import dce_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clr,
  input  wire logic       step,
  input  wire logic [4:0] code,
  input  wire logic [5:0] count,
  output logic      [5:0] pos
);
  dce_il_s    s_ff;
  dce_il_s    nxt_s;
  logic [6:0] sum;

  always_comb begin
    nxt_s = s_ff;
    sum   = {1'b0, s_ff.pos} + {2'b00, code};
    if (clr) begin
      nxt_s = '0;
    end else if (step) begin
      // Past the track end, restart one slot after the previous pass
      if (sum >= {1'b0, count}) begin
        nxt_s.base = s_ff.base + 6'h01;
        nxt_s.pos  = s_ff.base + 6'h01;
      end else begin
        nxt_s.pos = sum[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pos = s_ff.pos;
endmodule : dce_interleave

/* tb/dce_executor_assertions.sv */
// Checker of the executor link and media request outputs
`timescale 1ns/1ps
module dce_executor_checker
  import dce_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire dce_pkg::dce_link_in_s  link_in,
  input wire dce_pkg::dce_link_out_s link_out,
  input wire dce_pkg::dce_mreq_s     med_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    !link_out.req_b && !link_in.ack_b;
  endsequence
  AST_RST_IDLE: assert property ($rose(rst_b) |-> link_out.busy_b && link_out.req_b
    && !link_out.data_oe && !med_req.valid) else $error("link not idle after reset");
  AST_TAKE_RAISE: assert property (s_take |=> link_out.req_b)
    else $error("request held after byte taken");
  AST_REQ_STANDS: assert property (!link_out.req_b && link_in.ack_b && link_in.rst_b
    |=> !link_out.req_b) else $error("request dropped before acknowledge");
  AST_REQ_BUSY: assert property (!link_out.req_b |-> !link_out.busy_b)
    else $error("request while not busy");
  AST_OE_DIR: assert property (link_out.data_oe |-> !link_out.io_b)
    else $error("data driven with host direction");
  AST_PAR_ODD: assert property (link_out.data_oe && !link_out.req_b
    |-> link_out.par_b == ^link_out.data_b) else $error("outgoing parity not odd");
  AST_FILL: assert property (med_req.valid && med_req.op == MOP_IDFMT
    |-> med_req.fill == 8'h6C) else $error("format fill pattern wrong");
  AST_BAD_FMT: assert property (med_req.valid && med_req.bad
    |-> med_req.op == MOP_IDFMT) else $error("bad flag outside format");
  AST_PULSE: assert property (med_req.valid |=> !med_req.valid)
    else $error("media request longer than one cycle");
endmodule : dce_executor_checker
bind dce_executor dce_executor_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .link_in(link_in), .link_out(link_out), .med_req(med_req));

/* tb/dce_host_model.sv */
// Host adapter model: select, paced handshake, byte send and capture
`timescale 1ns/1ps
module dce_host_model
  import dce_pkg::*;
(
  input  wire logic                   sys_clk,
  output dce_pkg::dce_link_in_s       link_in,
  input  wire dce_pkg::dce_link_out_s link_out
);
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic       go = 1'b0;
  logic       bad_par = 1'b0;
  int         lag = 0;
  int         w = 0;
  initial link_in = '1;
  always @(posedge sys_clk) begin
    if (go && link_out.busy_b) link_in.sel_b <= 1'b0;
    if (!link_out.busy_b) link_in.sel_b <= 1'b1;
    if (!link_out.busy_b) go <= 1'b0;
    if (!link_out.req_b && link_in.ack_b) begin
      if (w < lag) w <= w + 1;
      else begin
        w <= 0;
        link_in.ack_b <= 1'b0;
        if (link_out.io_b) begin
          link_in.data_b <= ~tx[0];
          link_in.par_b <= ^tx[0] ^ bad_par;
          tx.delete(0);
        end else rx.push_back(~link_out.data_b);
      end
    end
    if (!link_in.ack_b && link_out.req_b) begin
      link_in.ack_b <= 1'b1;
      // Released lines float to the terminator level
      link_in.data_b <= 8'hFF;
      link_in.par_b <= 1'b1;
    end
  end
endmodule : dce_host_model

/* tb/tb_top.sv */
// Testbench: command sequences over the host link
`timescale 1ns/1ps
module tb_top;
  import dce_pkg::*;
  localparam logic [7:0] Z = 8'h00;
  logic          sys_clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [7:0]    unit_ready = 8'hFD;
  dce_link_in_s  link_in;
  dce_link_out_s link_out;
  dce_mreq_s     med_req;
  dce_mreq_s     seen;
  dce_mrsp_s     med_rsp = '0;
  dce_mrd_s      med_rd = '0;
  logic          med_wr_valid;
  logic [7:0]    med_wr_byte;
  logic [8:0]    mcnt = '0;
  logic [8:0]    wn = '0;
  logic [7:0]    q[$];
  dce_reg_s      reg_in = '0;
  logic [7:0]    reg_rdata;
  int            error_cnt = 0;
  int            cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  dce_executor DUT (.sys_clk(sys_clk), .rst_b(rst_b), .link_in(link_in), .link_out(link_out),
    .unit_ready(unit_ready), .med_req(med_req), .med_rsp(med_rsp), .med_rd(med_rd),
    .med_wr_valid(med_wr_valid), .med_wr_byte(med_wr_byte), .reg_in(reg_in),
    .reg_rdata(reg_rdata));
  dce_host_model host (.sys_clk(sys_clk), .link_in(link_in), .link_out(link_out));
  // Media streams a read as a count-down, ending with its last byte; others end next cycle
  always @(posedge sys_clk) begin
    med_rsp.done <= (med_req.valid && med_req.op != MOP_READ) || mcnt == 9'h001;
    med_rd.valid <= mcnt != 9'h000;
    med_rd.data  <= mcnt[7:0];
    if (med_req.valid && med_req.op == MOP_READ) mcnt <= med_req.size;
    else if (mcnt != 9'h000) mcnt <= mcnt - 9'h001;
    if (med_req.valid) seen <= med_req;
    if (med_wr_valid) begin
      chk(med_wr_byte, wn[7:0]);
      wn <= wn + 9'h001;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_in <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) reg_in <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk) reg_in <= '{a, Z, 1'b0, 1'b1};
    @(posedge sys_clk) reg_in <= '0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Runs one command; the last two bytes back are status and message
  task automatic cmd(input logic [7:0] b[$], input logic [7:0] st);
    int n;
    host.tx = b;
    host.rx.delete();
    @(posedge sys_clk) host.go <= 1'b1;
    // A command that never ends is left to the watchdog
    for (n = 0; n < 3 || host.go || !link_out.busy_b; n++) @(posedge sys_clk);
    chk(host.rx[host.rx.size()-2], st);
    chk(host.rx[host.rx.size()-1], Z);
  endtask : cmd
  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(4'h0, 8'h01);
    rd(4'hF, Z);
    cmd('{Z, 8'h20, Z, Z, Z, Z}, 8'h22);
    rd(4'h2, 8'h04);
    cmd('{8'h03, Z, Z, Z, Z, Z}, Z);
    chk(host.rx[0], 8'h04);
    chk(host.rx[1], 8'h20);
    cmd('{Z, Z, Z, Z, Z, Z}, Z);
    host.lag = 3;
    cmd('{8'h0B, 8'h01, 8'h23, 8'h45, 8'h01, Z}, Z);
    chk({3'h0, seen.lba[20:16]}, 8'h01);
    chk(seen.lba[15:8], 8'h23);
    chk({5'h00, seen.op}, {5'h00, MOP_SEEK});
    host.lag = 0;
    cmd('{8'h07, Z, Z, Z, 8'h01, Z}, Z);
    cmd('{8'h40, Z, Z, Z, Z, Z}, 8'h02);
    rd(4'h2, 8'h20);
    cmd('{8'h02, Z, Z, Z, Z, Z}, 8'h02);
    host.bad_par = 1'b1;
    cmd('{Z, Z, Z, Z, Z, Z}, 8'h03);
    rd(4'h2, 8'h1A);
    wr(4'h0, Z);
    cmd('{Z, Z, Z, Z, Z, Z}, Z);
    host.bad_par = 1'b0;
    wr(4'h0, 8'h01);
    cmd('{8'h08, Z, Z, 8'h07, 8'h01, Z}, Z);
    chk(host.rx[1], 8'hFF);
    chk(host.rx[255], 8'h01);
    chk(seen.lba[7:0], 8'h07);
    q = '{8'h0A, Z, Z, 8'h05, 8'h01, Z};
    for (int i = 0; i < 256; i++) q.push_back(i[7:0]);
    cmd(q, Z);
    chk(wn[8:1], 8'h80);
    chk({5'h00, seen.op}, {5'h00, MOP_WRITE});
    cmd('{8'hC0, 8'h20, Z, Z, 8'h02, Z}, 8'h20);
    cmd('{8'h0B, 8'h20, Z, 8'h30, Z, Z}, 8'h20);
    chk(seen.size[8:1], 8'h80);
    cmd('{8'h0B, 8'h20, Z, 8'h05, Z, Z}, 8'h20);
    chk(seen.size[8:1], 8'h40);
    report_and_stop();
  end
endmodule : tb_top
